//--- rtl/fifo_flags_pkg.sv
// constants shared by the dual-port fifo and its flag synchroniser
package fifo_flags_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int DEFAULT_DEPTH = 2048;
  localparam int DEFAULT_WIDTH = 36;
  // ----------------------------------------
  // synchronisation and reset values
  // ----------------------------------------
  localparam int SYNC_STAGES = 2;
  localparam logic MAIL_FLAG_RESET = 1'b1;
  localparam logic MODE_RESET = 1'b0;
  localparam logic CONFIG_DONE_RESET = 1'b0;
  localparam logic OUTPUT_READY_RESET = 1'b0;
endpackage : fifo_flags_pkg

//--- rtl/port_clock_edge.sv
// rising-edge detector for a port clock sampled by the system clock
`timescale 1ns/100ps
module port_clock_edge (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic port_clock_i,
  output logic rise_o
);
  logic last;
  logic next_last;

  always_comb
  begin
    next_last = port_clock_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      last <= 1'b1;
    else
      last <= next_last;
  end

  // starting high keeps a clock already high at reset from faking an edge
  assign rise_o = port_clock_i & ~last;
endmodule : port_clock_edge

//--- rtl/pointer_sync.sv
// pointer pipeline that advances one stage per rising edge of the far port clock
`timescale 1ns/100ps
module pointer_sync #(
  parameter int WIDTH = 12,
  parameter int STAGES = fifo_flags_pkg::SYNC_STAGES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic advance_i,
  input wire logic [WIDTH-1:0] pointer_i,
  output logic [WIDTH-1:0] pointer_o
);
  logic [WIDTH-1:0] stage [STAGES];
  logic [WIDTH-1:0] next_stage [STAGES];

  genvar i;
  generate
    for (i = 0; i < STAGES; i++)
    begin : g_stage
      always_comb
      begin
        next_stage[i] = stage[i];
        if (advance_i)
          next_stage[i] = (i == 0) ? pointer_i : stage[(i == 0) ? 0 : i - 1];
      end

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          stage[i] <= '0;
        else
          stage[i] <= next_stage[i];
      end
    end
  endgenerate

  assign pointer_o = stage[STAGES-1];
endmodule : pointer_sync

//--- rtl/dual_port_fifo.sv
// one-way fifo from port a to port b with mailboxes and synchronised status flags
// Contract
// - port a: deselected floats lines; write-direction enabled edge, mailbox low, writes fifo
// - port a mailbox: write direction stores first mail if its flag is high; read direction reads second, flag high
// - port b: deselected floats; low direction is input, enabled fifo edge does nothing
// - port b mailbox: input stores second mail if its flag is high; output reads first mail, flag high
// - fifo read needs select, output direction, enable, mailbox low, empty/ready high
// - fall-through: with ready low, next word loads on the edge raising ready
// - fall-through: with ready high, output register advances only on a selected read
// - standard mode: output register loads only on a fully selected read
// - flags pass two stages; full/almost-full on port a, empty/almost-empty on port b
// - flag levels follow stored count against depth and both offsets
// - word in output register is not counted as stored
// - word moved to output register frees its memory slot at once
// - fall-through: ready low keeps old word and ignores reads
// - standard: empty low keeps old word and ignores reads
// - read pointer steps per output load; write pointer per accepted write
// - fall-through: after write to empty, ready rises on third port b edge
// - standard: after write to empty, empty flag rises on second port b edge
// - counting starts on the first port edge after the event
// - full/ready low means full; writes then ignored
// - after read frees a slot, full flag rises on second port a edge
// - fifo write needs select, input direction, enable, mailbox low, full/ready high
`timescale 1ns/100ps
module dual_port_fifo #(
  parameter int DEPTH = fifo_flags_pkg::DEFAULT_DEPTH,
  parameter int WIDTH = fifo_flags_pkg::DEFAULT_WIDTH,
  parameter int AW = $clog2(DEPTH),
  parameter int PW = AW + 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fall_through_mode_i,
  input wire logic [PW-1:0] almost_empty_offset_i,
  input wire logic [PW-1:0] almost_full_offset_i,
  input wire logic port_a_clock_i,
  input wire logic port_a_chip_select_n_i,
  input wire logic port_a_direction_select_i,
  input wire logic port_a_enable_i,
  input wire logic port_a_mailbox_select_i,
  input wire logic [WIDTH-1:0] port_a_data_i,
  output logic [WIDTH-1:0] port_a_data_o,
  output logic port_a_data_oe_o,
  input wire logic port_b_clock_i,
  input wire logic port_b_chip_select_n_i,
  input wire logic port_b_direction_select_i,
  input wire logic port_b_enable_i,
  input wire logic port_b_mailbox_select_i,
  input wire logic [WIDTH-1:0] port_b_data_i,
  output logic [WIDTH-1:0] port_b_data_o,
  output logic port_b_data_oe_o,
  output logic empty_output_ready_flag_o,
  output logic almost_empty_flag_n_o,
  output logic almost_full_flag_n_o,
  output logic full_input_ready_flag_o,
  output logic first_mailbox_flag_n_o,
  output logic second_mailbox_flag_n_o
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [PW-1:0] DEPTH_COUNT = PW'(DEPTH);

  logic a_rise;
  logic b_rise;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] write_ptr;
  logic [PW-1:0] next_write_ptr;
  logic [PW-1:0] read_ptr;
  logic [PW-1:0] next_read_ptr;
  logic [PW-1:0] write_ptr_at_b;
  logic [PW-1:0] read_ptr_at_a;
  logic [WIDTH-1:0] output_word;
  logic [WIDTH-1:0] next_output_word;
  logic output_ready;
  logic next_output_ready;
  logic [WIDTH-1:0] first_mail_register;
  logic [WIDTH-1:0] next_first_mail_register;
  logic [WIDTH-1:0] second_mail_register;
  logic [WIDTH-1:0] next_second_mail_register;
  logic first_mail_flag_n;
  logic next_first_mail_flag_n;
  logic second_mail_flag_n;
  logic next_second_mail_flag_n;
  logic fall_through;
  logic next_fall_through;
  logic config_done;
  logic next_config_done;
  logic a_active;
  logic b_active;
  logic fifo_write;
  logic first_mail_write;
  logic second_mail_read;
  logic fifo_read_sel;
  logic second_mail_write;
  logic first_mail_read;
  logic word_waiting;
  logic load_output;
  logic [PW-1:0] count_at_a;
  logic [PW-1:0] count_at_b;
  logic full_ready;

  // ----------------------------------------
  // port clock edges and pointer synchronisers
  // ----------------------------------------
  port_clock_edge u_edge_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port_clock_i(port_a_clock_i),
    .rise_o(a_rise)
  );

  port_clock_edge u_edge_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port_clock_i(port_b_clock_i),
    .rise_o(b_rise)
  );

  // one clock domain here, so binary pointers are safe to stage
  pointer_sync #(.WIDTH(PW)) u_wptr_to_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .advance_i(b_rise),
    .pointer_i(write_ptr),
    .pointer_o(write_ptr_at_b)
  );

  pointer_sync #(.WIDTH(PW)) u_rptr_to_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .advance_i(a_rise),
    .pointer_i(read_ptr),
    .pointer_o(read_ptr_at_a)
  );

  // ----------------------------------------
  // timing-mode strap and configuration
  // ----------------------------------------
  always_comb
  begin
    next_config_done = 1'b1;
    // mode caught once after release; later changes are not followed
    next_fall_through = config_done ? fall_through : fall_through_mode_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      config_done <= fifo_flags_pkg::CONFIG_DONE_RESET;
      fall_through <= fifo_flags_pkg::MODE_RESET;
    end
    else
    begin
      config_done <= next_config_done;
      fall_through <= next_fall_through;
    end
  end

  // ----------------------------------------
  // port decode
  // ----------------------------------------
  assign a_active = a_rise & ~port_a_chip_select_n_i & port_a_enable_i;
  assign b_active = b_rise & ~port_b_chip_select_n_i & port_b_enable_i;
  assign fifo_write = a_active & port_a_direction_select_i & ~port_a_mailbox_select_i & full_ready;
  assign first_mail_write = a_active & port_a_direction_select_i & port_a_mailbox_select_i & first_mail_flag_n;
  assign second_mail_read = a_active & ~port_a_direction_select_i & port_a_mailbox_select_i;
  // input direction with mailbox low is a no-op on port b
  assign second_mail_write = b_active & ~port_b_direction_select_i & port_b_mailbox_select_i & second_mail_flag_n;
  assign first_mail_read = b_active & port_b_direction_select_i & port_b_mailbox_select_i;
  assign fifo_read_sel = b_active & port_b_direction_select_i & ~port_b_mailbox_select_i;

  // ----------------------------------------
  // write side
  // ----------------------------------------
  always_comb
  begin
    next_write_ptr = write_ptr;
    if (fifo_write)
      next_write_ptr = write_ptr + PW'(1);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      write_ptr <= '0;
    else
      write_ptr <= next_write_ptr;
  end

  always_ff @(posedge clk_i)
  begin
    if (fifo_write)
      mem[write_ptr[AW-1:0]] <= port_a_data_i;
  end

  // ----------------------------------------
  // read side and output register
  // ----------------------------------------
  assign word_waiting = (write_ptr_at_b != read_ptr);

  always_comb
  begin
    next_output_ready = output_ready;
    if (fall_through)
    begin
      // with ready low a waiting word drops in unrequested
      load_output = b_rise & word_waiting & (~output_ready | fifo_read_sel);
      if (b_rise & ~output_ready & word_waiting)
        next_output_ready = 1'b1;
      else if (output_ready & fifo_read_sel)
        next_output_ready = word_waiting;
    end
    else
    begin
      load_output = fifo_read_sel & word_waiting;
      next_output_ready = 1'b0;
    end
  end

  always_comb
  begin
    next_read_ptr = read_ptr;
    next_output_word = output_word;
    if (load_output)
    begin
      next_output_word = mem[read_ptr[AW-1:0]];
      // slot is released the moment its word leaves memory
      next_read_ptr = read_ptr + PW'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      read_ptr <= '0;
      output_word <= '0;
      output_ready <= fifo_flags_pkg::OUTPUT_READY_RESET;
    end
    else
    begin
      read_ptr <= next_read_ptr;
      output_word <= next_output_word;
      output_ready <= next_output_ready;
    end
  end

  // ----------------------------------------
  // mailboxes
  // ----------------------------------------
  always_comb
  begin
    next_first_mail_register = first_mail_register;
    next_second_mail_register = second_mail_register;
    next_first_mail_flag_n = first_mail_flag_n;
    next_second_mail_flag_n = second_mail_flag_n;
    if (first_mail_write)
    begin
      next_first_mail_register = port_a_data_i;
      next_first_mail_flag_n = 1'b0;
    end
    else if (first_mail_read)
      next_first_mail_flag_n = 1'b1;
    if (second_mail_write)
    begin
      next_second_mail_register = port_b_data_i;
      next_second_mail_flag_n = 1'b0;
    end
    else if (second_mail_read)
      next_second_mail_flag_n = 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      first_mail_register <= '0;
      second_mail_register <= '0;
      first_mail_flag_n <= fifo_flags_pkg::MAIL_FLAG_RESET;
      second_mail_flag_n <= fifo_flags_pkg::MAIL_FLAG_RESET;
    end
    else
    begin
      first_mail_register <= next_first_mail_register;
      second_mail_register <= next_second_mail_register;
      first_mail_flag_n <= next_first_mail_flag_n;
      second_mail_flag_n <= next_second_mail_flag_n;
    end
  end

  // ----------------------------------------
  // data pins
  // ----------------------------------------
  assign port_a_data_oe_o = ~port_a_chip_select_n_i & ~port_a_direction_select_i;
  assign port_a_data_o = port_a_mailbox_select_i ? second_mail_register : '0;
  assign port_b_data_oe_o = ~port_b_chip_select_n_i & port_b_direction_select_i;
  assign port_b_data_o = port_b_mailbox_select_i ? first_mail_register : output_word;

  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign count_at_b = write_ptr_at_b - read_ptr;
  assign count_at_a = write_ptr - read_ptr_at_a;
  assign full_ready = config_done & (count_at_a != DEPTH_COUNT);

  assign empty_output_ready_flag_o = fall_through ? output_ready : word_waiting;
  assign almost_empty_flag_n_o = (count_at_b > almost_empty_offset_i);
  assign almost_full_flag_n_o = ~config_done | (count_at_a < (DEPTH_COUNT - almost_full_offset_i));
  assign full_input_ready_flag_o = full_ready;
  assign first_mailbox_flag_n_o = first_mail_flag_n;
  assign second_mailbox_flag_n_o = second_mail_flag_n;
endmodule : dual_port_fifo

//--- bench/dual_port_fifo_checker.sv
// port-level checker bound to the dual-port fifo
`timescale 1ns/100ps
module dual_port_fifo_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic port_a_clock_i,
  input wire logic port_a_chip_select_n_i,
  input wire logic port_a_direction_select_i,
  input wire logic port_a_enable_i,
  input wire logic port_a_mailbox_select_i,
  input wire logic port_b_clock_i,
  input wire logic port_b_chip_select_n_i,
  input wire logic port_b_direction_select_i,
  input wire logic port_b_enable_i,
  input wire logic port_b_mailbox_select_i,
  input wire logic port_a_data_oe_o,
  input wire logic port_b_data_oe_o,
  input wire logic empty_output_ready_flag_o,
  input wire logic almost_empty_flag_n_o,
  input wire logic almost_full_flag_n_o,
  input wire logic full_input_ready_flag_o,
  input wire logic first_mailbox_flag_n_o
);
  // ----
  // port clock rises, sampled as the design does
  // ----
  logic a_q;
  logic b_q;
  logic [1:0] up;
  logic [1:0] next_up;
  logic rise_a;
  logic rise_b;
  logic mw1;
  logic mr1;
  always_comb
  begin
    next_up = up + {1'b0, up != 2'h3};
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      a_q <= 1'b1;
      b_q <= 1'b1;
      up <= 2'h0;
    end
    else
    begin
      a_q <= port_a_clock_i;
      b_q <= port_b_clock_i;
      up <= next_up;
    end
  end
  assign rise_a = port_a_clock_i & ~a_q;
  assign rise_b = port_b_clock_i & ~b_q;
  assign mw1 = rise_a & ~port_a_chip_select_n_i & port_a_enable_i & port_a_direction_select_i & port_a_mailbox_select_i;
  assign mr1 = rise_b & ~port_b_chip_select_n_i & port_b_enable_i & port_b_direction_select_i & port_b_mailbox_select_i;
  // ----
  // properties
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_drive_a: assert property (port_a_data_oe_o == (~port_a_chip_select_n_i & ~port_a_direction_select_i))
    else $error("port a drive enable wrong");
  b_drive_a: assert property (port_b_data_oe_o == (~port_b_chip_select_n_i & port_b_direction_select_i))
    else $error("port b drive enable wrong");
  empty_sync_a: assert property ($changed(empty_output_ready_flag_o) |-> $past(rise_b))
    else $error("ready flag moved off a port b rise");
  near_empty_a: assert property ($changed(almost_empty_flag_n_o) |-> $past(rise_b))
    else $error("almost empty moved off a port b rise");
  near_full_a: assert property ($changed(almost_full_flag_n_o) |-> $past(rise_a))
    else $error("almost full moved off a port a rise");
  full_sync_a: assert property (up == 2'h3 && $changed(full_input_ready_flag_o) |-> $past(rise_a))
    else $error("full flag moved off a port a rise");
  full_near_a: assert property (up == 2'h3 && !full_input_ready_flag_o |-> !almost_full_flag_n_o)
    else $error("full without almost full");
  mail_set_a: assert property (mw1 |=> !first_mailbox_flag_n_o)
    else $error("mail one flag not set");
  mail_clear_a: assert property (mr1 && !mw1 |=> first_mailbox_flag_n_o)
    else $error("mail one flag not cleared");
  cover property (mw1);
  cover property (mr1);
  cover property ($rose(empty_output_ready_flag_o));
endmodule : dual_port_fifo_checker
bind dual_port_fifo dual_port_fifo_checker u_dual_port_fifo_checker (.*);

//--- bench/port_host_model.sv
// host model driving both ports of the fifo
`timescale 1ns/100ps
module port_host_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic a_clock_o,
  output logic [3:0] a_ctl_o,
  output logic [35:0] a_data_o,
  output logic b_clock_o,
  output logic [3:0] b_ctl_o,
  output logic [35:0] b_data_o,
  output logic taken_o
);
  // ctl is {select_n, direction, enable, mailbox}
  initial {a_clock_o, a_data_o, b_clock_o, b_data_o, taken_o} = '0;
  initial {a_ctl_o, b_ctl_o} = 8'h88;
  task automatic a_op(input logic [3:0] c, input logic [35:0] d);
    @(posedge clk_i);
    a_ctl_o <= c;
    a_data_o <= d;
    @(posedge clk_i);
    a_clock_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    a_clock_o <= 1'b0;
    a_ctl_o[1] <= 1'b0;
    a_data_o <= ~d;
  endtask : a_op
  task automatic b_op(input logic [3:0] c, input logic [35:0] d);
    @(posedge clk_i);
    b_ctl_o <= c;
    b_data_o <= d;
    @(posedge clk_i);
    b_clock_o <= 1'b1;
    @(posedge clk_i);
    taken_o <= (c == 4'h6) & ready_i;
    @(posedge clk_i);
    taken_o <= 1'b0;
    b_clock_o <= 1'b0;
    b_ctl_o[1] <= 1'b0;
    b_data_o <= ~d;
  endtask : b_op
endmodule : port_host_model

//--- bench/dual_clock_fifo_ports_flags_tb_top.sv
// self-checking bench for the dual-port fifo
`timescale 1ns/100ps
module dual_clock_fifo_ports_flags_tb_top;
  localparam int DEPTH = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fall_through_mode_i = 1'b0;
  logic [3:0] almost_empty_offset_i = 4'h2;
  logic [3:0] almost_full_offset_i = 4'h2;
  logic port_a_clock_i, port_a_chip_select_n_i, port_a_direction_select_i, port_a_enable_i, port_a_mailbox_select_i;
  logic port_b_clock_i, port_b_chip_select_n_i, port_b_direction_select_i, port_b_enable_i, port_b_mailbox_select_i;
  logic [35:0] port_a_data_i, port_a_data_o, port_b_data_i, port_b_data_o;
  logic port_a_data_oe_o, port_b_data_oe_o, empty_output_ready_flag_o, almost_empty_flag_n_o, almost_full_flag_n_o;
  logic full_input_ready_flag_o, first_mailbox_flag_n_o, second_mailbox_flag_n_o, taken, ready_q;
  logic [35:0] q[$];
  int errors = 0;
  int samples_checked = 0;
  always #5 clk_i = ~clk_i;
  dual_port_fifo #(.DEPTH(DEPTH)) u_dual_port_fifo (.*);
  port_host_model u_port_host_model (.clk_i(clk_i), .ready_i(empty_output_ready_flag_o),
    .a_clock_o(port_a_clock_i), .a_data_o(port_a_data_i), .b_clock_o(port_b_clock_i), .b_data_o(port_b_data_i),
    .a_ctl_o({port_a_chip_select_n_i, port_a_direction_select_i, port_a_enable_i, port_a_mailbox_select_i}),
    .b_ctl_o({port_b_chip_select_n_i, port_b_direction_select_i, port_b_enable_i, port_b_mailbox_select_i}),
    .taken_o(taken));
  // ----
  // shared tasks
  // ----
  task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic put(input logic [35:0] d);
    if (full_input_ready_flag_o === 1'b1)
      q.push_back(d);
    u_port_host_model.a_op(4'h6, d);
  endtask : put
  task automatic restart(input logic m);
    rst_i <= 1'b1;
    fall_through_mode_i <= m;
    q.delete();
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : restart
  // ----
  // word watcher: a new output word pops the oldest note
  // ----
  always @(posedge clk_i)
  begin
    ready_q <= empty_output_ready_flag_o;
    if (!rst_i && (taken && (!fall_through_mode_i || empty_output_ready_flag_o)
        || fall_through_mode_i && empty_output_ready_flag_o && !ready_q))
      check(port_b_data_o, (q.size() > 0) ? q.pop_front() : ~port_b_data_o, "word");
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end
  initial
  begin
    logic [35:0] d;
    void'($urandom(32'h9944));
    for (int m = 0; m < 2; m++)
    begin
      restart(m[0]);
      check(36'(full_input_ready_flag_o), 36'h1, "full reset");
      check(36'(empty_output_ready_flag_o), 36'h0, "ready reset");
      put(36'($urandom));
      for (int i = 1; i <= 3; i++)
      begin
        u_port_host_model.b_op(4'h2, 36'h0);
        check(36'(empty_output_ready_flag_o), 36'(i >= 2 + m), "ready latency");
      end
      u_port_host_model.b_op(4'h6, 36'h0);
      for (int i = 0; i <= DEPTH; i++)
        put(36'($urandom));
      check(36'(q.size()), 36'(DEPTH), "accepted");
      check(36'(almost_full_flag_n_o), 36'h0, "almost full");
      repeat (3) u_port_host_model.b_op(4'h2, 36'h0);
      check(36'(almost_empty_flag_n_o), 36'h1, "almost empty");
      u_port_host_model.b_op(4'h6, 36'h0);
      u_port_host_model.a_op(4'h2, 36'h0);
      check(36'(full_input_ready_flag_o), 36'h0, "full one rise");
      u_port_host_model.a_op(4'h2, 36'h0);
      check(36'(full_input_ready_flag_o), 36'h1, "full two rises");
      for (int i = 0; i < DEPTH + 2 && empty_output_ready_flag_o === 1'b1; i++)
        u_port_host_model.b_op(4'h6, 36'h0);
      u_port_host_model.b_op(4'h6, 36'h0);
      check(36'(q.size()), 36'h0, "drained");
      check(36'(almost_empty_flag_n_o), 36'h0, "almost empty low");
    end
    d = 36'($urandom);
    u_port_host_model.a_op(4'h7, d);
    u_port_host_model.a_op(4'h7, ~d);
    check(36'(first_mailbox_flag_n_o), 36'h0, "mail one flag");
    u_port_host_model.b_op(4'h7, 36'h0);
    check(port_b_data_o, d, "mail one data");
    check(36'(first_mailbox_flag_n_o), 36'h1, "mail one read");
    u_port_host_model.b_op(4'h3, ~d);
    check(36'(second_mailbox_flag_n_o), 36'h0, "mail two flag");
    u_port_host_model.a_op(4'h3, 36'h0);
    check(port_a_data_o, ~d, "mail two data");
    check(36'(second_mailbox_flag_n_o), 36'h1, "mail two read");
    report_and_stop();
  end
endmodule : dual_clock_fifo_ports_flags_tb_top
